// ===== hw/adcwg_pkg.sv
// package of constants and carriers for the converter register wait generator
package adcwg_pkg;

    // register bus geometry
    localparam int unsigned ADCWG_AW = 8;
    localparam int unsigned ADCWG_DW = 32;
    localparam logic [ADCWG_AW-1:0] ADCWG_OFS_CTRL = 8'h00;
    localparam logic [ADCWG_AW-1:0] ADCWG_OFS_STAT = 8'h04;

    // control register fields
    localparam int unsigned ADCWG_DIV_W = 3;
    localparam int unsigned ADCWG_CTRL_DIV_LSB = 0;
    localparam logic [ADCWG_DIV_W-1:0] ADCWG_DIV_RST = 3'h0;
    localparam logic [ADCWG_DIV_W-1:0] ADCWG_DIV_MAX = 3'h4;

    // status register fields
    localparam int unsigned ADCWG_STAT_SPEED = 0;
    localparam int unsigned ADCWG_STAT_BUSY = 1;
    localparam int unsigned ADCWG_STAT_OSCV = 2;
    localparam int unsigned ADCWG_STAT_WAIT_LSB = 8;

    // converter mode register: speed select bit position and reset value
    localparam int unsigned ADCWG_SPEED_BIT = 5;
    localparam logic ADCWG_SPEED_RST = 1'b0;

    // wait counter width, enough for the largest count of nine
    localparam int unsigned ADCWG_CNT_W = 4;

    // timing of the converter side, in its own units
    localparam int unsigned ADCWG_MAIN_FREQ_KHZ = 10000;
    localparam int unsigned ADCWG_MAIN_PERIOD_NS = 1000000 / ADCWG_MAIN_FREQ_KHZ;
    localparam int unsigned ADCWG_CPU_LOW_NS = 50;
    // macro clock divider from the main input, speed select 0 and 1
    localparam int unsigned ADCWG_MACRO_DIV_SLOW = 2;
    localparam int unsigned ADCWG_MACRO_DIV_FAST = 1;
    // macro periods spanned by one access, and main periods per macro count
    localparam int unsigned ADCWG_MACRO_PERIODS = 2;
    localparam int unsigned ADCWG_PERIOD_SCALE = 2;
    localparam int unsigned ADCWG_WAIT_EXTRA = 1;
    localparam logic [ADCWG_CNT_W-1:0] ADCWG_READ_MIN = 4'h1;

    // converter register targeted by a cpu access
    typedef enum logic [2:0] {
        ADCWG_TGT_OTHER,
        ADCWG_TGT_MODE,
        ADCWG_TGT_CHAN,
        ADCWG_TGT_PFCMP,
        ADCWG_TGT_PFTHR,
        ADCWG_TGT_RESULT
    } adcwg_target_t;

    // one cpu access on the peripheral bus, valid for a single cycle
    typedef struct packed {
        logic valid;
        logic we;
        adcwg_target_t target;
        logic [7:0] wdata;
    } adcwg_cpu_acc_t;

    // wishbone request and answer bundles
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADCWG_AW-1:0] adr;
        logic [3:0] sel;
        logic [ADCWG_DW-1:0] dat;
    } adcwg_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [ADCWG_DW-1:0] dat;
    } adcwg_wb_rsp_t;

endpackage : adcwg_pkg

// ===== hw/adcwg_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module adcwg_sync
    import adcwg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic meta;
        logic stable;
    } adcwg_sync_state_t;

    adcwg_sync_state_t st;
    adcwg_sync_state_t next_st;

    // first stage feeds only the second stage
    always_comb begin
        next_st = st;
        next_st.meta = d_i;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.stable;

endmodule : adcwg_sync

// ===== hw/adcwg_wait_cnt.sv
// down counter that holds the cpu wait line for a loaded number of cycles
`timescale 1ns/1ps
module adcwg_wait_cnt
    import adcwg_pkg::*;
#(
    parameter int unsigned CNT_W = ADCWG_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [CNT_W-1:0] load_val_i,
    output logic busy_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic busy;
    } adcwg_cnt_state_t;

    adcwg_cnt_state_t st;
    adcwg_cnt_state_t next_st;

    // a load while busy is ignored: the cpu is already held off
    always_comb begin
        next_st = st;
        if (!st.busy && load_i) begin
            next_st.cnt = load_val_i;
            next_st.busy = (load_val_i != '0);
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
            next_st.busy = (st.cnt > 1);   // release in the same cycle the count reaches zero
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = st.busy;

    a_busy_follows_cnt: assert property (
        @(posedge clk_i) disable iff (rst_i) st.busy == (st.cnt != '0))
        else $error("wait line disagrees with counter");

    a_load_two_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!st.busy && load_i && load_val_i == 2) |=> st.busy [*2] ##1 !st.busy)
        else $error("two cycle wait not held for exactly two cycles");

endmodule : adcwg_wait_cnt

// ===== hw/adcwg_top.sv
// wait-state generator for cpu accesses to the converter registers
//
// Functional notes
// - wait on converter setup register writes, result reads
// - max wait is two macro periods plus one
// - fraction up to cpu low width dropped, else up unless no whole clock
// - speed select 0 gives macro clock main/2
// - computed count of one means no wait
// - reads 1..5 or 1..9, writes 2..5 or 2..9
// - table waits 9,5,3,2,0 and 5,3,2,0,0
// - zero wait still costs result read one clock
`timescale 1ns/1ps
module adcwg_top
    import adcwg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire adcwg_wb_req_t wb_req_i,
    output adcwg_wb_rsp_t wb_rsp_o,
    input wire adcwg_cpu_acc_t cpu_acc_i,
    input wire logic main_osc_stop_control_i,
    output logic cpu_wait_o,
    output logic conversion_speed_select_o
);
    typedef struct packed {
        logic [ADCWG_DIV_W-1:0] div;
        logic speed;
        logic osc_viol;
        logic [ADCWG_CNT_W-1:0] last_wait;
        logic ack;
        logic [ADCWG_DW-1:0] rdat;
    } adcwg_state_t;

    localparam int unsigned FRAC_W = 16;
    localparam logic [FRAC_W-1:0] K_SLOW = FRAC_W'(ADCWG_MACRO_PERIODS * ADCWG_MACRO_DIV_SLOW
                                                   * ADCWG_PERIOD_SCALE);
    localparam logic [FRAC_W-1:0] K_FAST = FRAC_W'(ADCWG_MACRO_PERIODS * ADCWG_MACRO_DIV_FAST
                                                   * ADCWG_PERIOD_SCALE);
    localparam logic [FRAC_W-1:0] MAIN_NS = FRAC_W'(ADCWG_MAIN_PERIOD_NS);
    localparam logic [FRAC_W-1:0] LOW_NS = FRAC_W'(ADCWG_CPU_LOW_NS);
    localparam logic [ADCWG_CNT_W-1:0] EXTRA = ADCWG_CNT_W'(ADCWG_WAIT_EXTRA);

    adcwg_state_t st;
    adcwg_state_t next_st;
    logic osc_stopped;
    logic wait_busy;
    logic [FRAC_W-1:0] macro_prod;
    logic [FRAC_W-1:0] quot;
    logic [FRAC_W-1:0] rem;
    logic [FRAC_W-1:0] rem_ns;
    logic round_up;
    logic [ADCWG_CNT_W-1:0] formula_wait;
    logic [ADCWG_CNT_W-1:0] access_wait;
    logic waiting_access;
    logic is_read;
    logic start_wait;
    logic wb_req;
    logic wb_wr_ctrl;
    logic wb_wr_stat;

    // oscillator stop level arrives from another domain
    adcwg_sync u_osc_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(main_osc_stop_control_i),
        .q_o(osc_stopped)
    );

    // macro period product over one cpu period, both in main input periods
    always_comb begin
        macro_prod = st.speed ? K_FAST : K_SLOW;
        quot = macro_prod >> st.div;
        rem = macro_prod & ((FRAC_W'(1) << st.div) - FRAC_W'(1));
        rem_ns = FRAC_W'(rem * MAIN_NS);
        // a leftover fraction only rounds up behind a whole cpu clock
        round_up = (quot != '0) && (rem_ns > LOW_NS);
        formula_wait = ADCWG_CNT_W'(quot) + ADCWG_CNT_W'(round_up) + EXTRA;
    end

    // which accesses wait, and for how long
    always_comb begin
        is_read = cpu_acc_i.valid && !cpu_acc_i.we;
        case (cpu_acc_i.target)
            ADCWG_TGT_MODE, ADCWG_TGT_CHAN, ADCWG_TGT_PFCMP, ADCWG_TGT_PFTHR: begin
                waiting_access = cpu_acc_i.valid && cpu_acc_i.we;
            end
            ADCWG_TGT_RESULT: begin
                waiting_access = is_read;
            end
            default: begin
                waiting_access = 1'b0;
            end
        endcase
        if (formula_wait == EXTRA) begin
            // a lone extra clock collapses to none, result reads keep one
            access_wait = (cpu_acc_i.target == ADCWG_TGT_RESULT) ? ADCWG_READ_MIN : '0;
        end else begin
            access_wait = formula_wait;
        end
        start_wait = waiting_access && !wait_busy;
    end

    adcwg_wait_cnt #(
        .CNT_W(ADCWG_CNT_W)
    ) u_wait_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(start_wait),
        .load_val_i(access_wait),
        .busy_o(wait_busy)
    );

    // wishbone decode: single cycle ack, dropped the cycle after
    always_comb begin
        wb_req = wb_req_i.cyc && wb_req_i.stb && !st.ack;
        wb_wr_ctrl = wb_req && wb_req_i.we && (wb_req_i.adr == ADCWG_OFS_CTRL)
                     && wb_req_i.sel[0];
        wb_wr_stat = wb_req && wb_req_i.we && (wb_req_i.adr == ADCWG_OFS_STAT)
                     && wb_req_i.sel[0];
    end

    // register file and converter mode shadow
    always_comb begin
        next_st = st;
        next_st.ack = wb_req;
        if (wb_wr_ctrl) begin
            if (wb_req_i.dat[ADCWG_CTRL_DIV_LSB +: ADCWG_DIV_W] <= ADCWG_DIV_MAX) begin
                next_st.div = wb_req_i.dat[ADCWG_CTRL_DIV_LSB +: ADCWG_DIV_W];
            end
        end
        // the mode write itself waits on the old speed, later ones on the new
        if (cpu_acc_i.valid && cpu_acc_i.we && cpu_acc_i.target == ADCWG_TGT_MODE) begin
            next_st.speed = cpu_acc_i.wdata[ADCWG_SPEED_BIT];
        end
        if (start_wait) begin
            next_st.last_wait = access_wait;
        end
        // write one clears; a new violation in the same cycle wins
        if (wb_wr_stat && wb_req_i.dat[ADCWG_STAT_OSCV]) begin
            next_st.osc_viol = 1'b0;
        end
        if (waiting_access && osc_stopped) begin
            next_st.osc_viol = 1'b1;
        end
        next_st.rdat = '0;
        if (wb_req && !wb_req_i.we) begin
            case (wb_req_i.adr)
                ADCWG_OFS_CTRL: begin
                    next_st.rdat[ADCWG_CTRL_DIV_LSB +: ADCWG_DIV_W] = st.div;
                end
                ADCWG_OFS_STAT: begin
                    next_st.rdat[ADCWG_STAT_SPEED] = st.speed;
                    next_st.rdat[ADCWG_STAT_BUSY] = wait_busy;
                    next_st.rdat[ADCWG_STAT_OSCV] = st.osc_viol;
                    next_st.rdat[ADCWG_STAT_WAIT_LSB +: ADCWG_CNT_W] = st.last_wait;
                end
                default: begin
                    next_st.rdat = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.div <= ADCWG_DIV_RST;
            st.speed <= ADCWG_SPEED_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs come straight from flops
    assign wb_rsp_o.ack = st.ack;
    assign wb_rsp_o.dat = st.rdat;
    assign cpu_wait_o = wait_busy;
    assign conversion_speed_select_o = st.speed;

    a_no_wait_other: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cpu_acc_i.valid && cpu_acc_i.target == ADCWG_TGT_OTHER && !wait_busy) |=> !cpu_wait_o)
        else $error("wait raised for a register that never waits");

    a_result_read_min: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && is_read) |=> cpu_wait_o)
        else $error("result read did not wait at least one clock");

    a_slow_full_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && !st.speed && st.div == 3'h0) |-> access_wait == 4'h9)
        else $error("speed 0 undivided cpu clock must wait nine clocks");

    a_fast_div_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && st.speed && st.div == 3'h1) |-> access_wait == 4'h3)
        else $error("speed 1 halved cpu clock must wait three clocks");

    a_write_zero_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && cpu_acc_i.we && st.speed && st.div == 3'h3) |=> !cpu_wait_o)
        else $error("unit formula result must not stall a write");

    a_write_range: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && cpu_acc_i.we && access_wait != '0)
            |-> (access_wait >= 4'h2 && access_wait <= (st.speed ? 4'h5 : 4'h9)))
        else $error("write wait outside its allowed range");

    a_wait_length: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && !st.speed && st.div == 3'h2) |=> cpu_wait_o [*3] ##1 !cpu_wait_o)
        else $error("quarter clock slow wait is not three clocks long");

    a_osc_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (waiting_access && osc_stopped) |=> st.osc_viol)
        else $error("access with oscillator stopped not flagged");

    // remaining table points, so every divider and speed pair is pinned down
    a_slow_half_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && !st.speed && st.div == 3'h1) |-> access_wait == 4'h5)
        else $error("speed 0 halved cpu clock must wait five clocks");

    a_slow_eighth_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && !st.speed && st.div == 3'h3) |-> access_wait == 4'h2)
        else $error("speed 0 eighth cpu clock must wait two clocks");

    a_slow_last_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && !st.speed && st.div == 3'h4) |-> access_wait == (is_read ? 4'h1 : 4'h0))
        else $error("speed 0 slowest cpu clock wait is wrong");

    a_fast_full_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && st.speed && st.div == 3'h0) |-> access_wait == 4'h5)
        else $error("speed 1 undivided cpu clock must wait five clocks");

    a_fast_quarter_wait: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && st.speed && st.div == 3'h2) |-> access_wait == 4'h2)
        else $error("speed 1 quarter cpu clock must wait two clocks");

    a_fast_eighth_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && is_read && st.speed && st.div == 3'h3) |-> access_wait == 4'h1)
        else $error("result read with zero computed wait must still wait one");

    a_fast_last_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && cpu_acc_i.we && st.speed && st.div == 3'h4) |-> access_wait == 4'h0)
        else $error("write at slowest cpu clock must not stall");

    a_read_range: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && is_read)
            |-> (access_wait >= 4'h1 && access_wait <= (st.speed ? 4'h5 : 4'h9)))
        else $error("read wait outside its allowed range");

    // accesses that never wait, while the counter is idle
    a_no_wait_wr_result: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cpu_acc_i.valid && cpu_acc_i.we && cpu_acc_i.target == ADCWG_TGT_RESULT
            && !wait_busy) |=> !cpu_wait_o)
        else $error("write to the result register raised a wait");

    a_no_wait_cfg_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (is_read && cpu_acc_i.target != ADCWG_TGT_RESULT && !wait_busy) |=> !cpu_wait_o)
        else $error("read of a setup register raised a wait");

    a_nine_wait_len: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && !st.speed && st.div == 3'h0)
            |=> cpu_wait_o [*8] ##1 cpu_wait_o ##1 !cpu_wait_o)
        else $error("full slow wait is not nine clocks long");

    a_speed_from_mode: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (start_wait && cpu_acc_i.we && cpu_acc_i.target == ADCWG_TGT_MODE)
            |=> st.speed == $past(cpu_acc_i.wdata[ADCWG_SPEED_BIT]))
        else $error("speed select not taken from the mode write");

    a_mode_read_keeps: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cpu_acc_i.valid && !cpu_acc_i.we && cpu_acc_i.target == ADCWG_TGT_MODE)
            |=> st.speed == $past(st.speed))
        else $error("mode read changed the speed select");

    // sticky misuse flag: cleared only by a one written, kept otherwise
    a_osc_flag_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_wr_stat && wb_req_i.dat[ADCWG_STAT_OSCV] && !(waiting_access && osc_stopped))
            |=> !st.osc_viol)
        else $error("oscillator misuse flag not cleared");

    a_osc_flag_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.osc_viol && !wb_wr_stat) |=> st.osc_viol)
        else $error("oscillator misuse flag lost without a clear");

    a_div_refused: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_wr_ctrl && wb_req_i.dat[ADCWG_CTRL_DIV_LSB +: ADCWG_DIV_W] > ADCWG_DIV_MAX)
            |=> st.div == $past(st.div))
        else $error("out of range divider code was taken");

    a_read_idle_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !wb_rsp_o.ack |-> wb_rsp_o.dat == '0)
        else $error("read data not zero outside the ack cycle");

    a_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

endmodule : adcwg_top

// ===== dv/adcwg_cpu_model.sv
// cpu core model issuing converter register accesses on the peripheral bus
`timescale 1ns/1ps
module adcwg_cpu_model
    import adcwg_pkg::*;
(
    input wire logic clk_i,
    input wire logic cpu_wait_i,
    output adcwg_cpu_acc_t cpu_acc_o
);
    // bus idle from time zero
    initial begin
        cpu_acc_o = '0;
    end

    // one access pulse, then count the stall cycles that follow it
    task automatic access(input logic we, input adcwg_target_t tgt, input logic [7:0] wd,
                          output int n);
        n = 0;
        cpu_acc_o <= '{valid: 1'b1, we: we, target: tgt, wdata: wd};
        @(posedge clk_i);
        cpu_acc_o.valid <= 1'b0;
        // no new access while stalled; an unknown wait counts as released
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (cpu_wait_i !== 1'b1) break;
            n++;
        end
    endtask : access
endmodule : adcwg_cpu_model

// ===== dv/adcwg_top_test.sv
// self-checking bench for the converter register wait generator
`timescale 1ns/1ps
module adcwg_top_test
    import adcwg_pkg::*;
;
    logic clk_i;
    logic rst_i;
    logic osc_stop;
    logic cpu_wait;
    logic speed_sel;
    adcwg_wb_req_t wb_req;
    adcwg_wb_rsp_t wb_rsp;
    adcwg_cpu_acc_t cpu_acc;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h558e42d8;
    // reference wait table, rows by speed select, columns by divider code
    int tbl [2][5] = '{'{9, 5, 3, 2, 0}, '{5, 3, 2, 0, 0}};

    adcwg_top dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req),
        .wb_rsp_o(wb_rsp),
        .cpu_acc_i(cpu_acc),
        .main_osc_stop_control_i(osc_stop),
        .cpu_wait_o(cpu_wait),
        .conversion_speed_select_o(speed_sel)
    );

    adcwg_cpu_model cpu_u (
        .clk_i(clk_i),
        .cpu_wait_i(cpu_wait),
        .cpu_acc_o(cpu_acc)
    );

    // free-running clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd

    // expected stall; a computed one collapses to none, result reads keep one
    function automatic int exp_wait(int s, int d, logic we, adcwg_target_t t);
        if (we && t inside {ADCWG_TGT_MODE, ADCWG_TGT_CHAN, ADCWG_TGT_PFCMP, ADCWG_TGT_PFTHR})
            return tbl[s][d];
        if (!we && t == ADCWG_TGT_RESULT)
            return (tbl[s][d] == 0) ? 1 : tbl[s][d];
        return 0;
    endfunction : exp_wait

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (wb_rsp.ack === 1'b1) break;
        end
        // a missing answer is a failure in its own right
        if (wb_rsp.ack !== 1'b1) mismatches++;
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk_i);
    endtask : wb_xfer

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // hang guard, far above the several hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    // main sequence: every speed, divider, target and direction
    initial begin
        logic [31:0] rd;
        logic [7:0] wd;
        int n;
        int e;
        int m_speed;
        rst_i = 1'b1;
        wb_req = '0;
        osc_stop = 1'b0; // oscillator kept running until the deliberate misuse at the end
        m_speed = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb_xfer(1'b0, ADCWG_OFS_CTRL, 32'h0, rd);
        chk("ctrl_reset", rd, 32'h0);
        wb_xfer(1'b0, ADCWG_OFS_STAT, 32'h0, rd);
        chk("stat_reset", rd, 32'h0);
        wb_xfer(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped_read", rd, 32'h0);
        // divider code above the largest is refused
        wb_xfer(1'b1, ADCWG_OFS_CTRL, 32'h5, rd);
        wb_xfer(1'b0, ADCWG_OFS_CTRL, 32'h0, rd);
        chk("ctrl_refused", {29'h0, rd[2:0]}, 32'h0);
        for (int s = 0; s < 2; s++) begin
            for (int d = 0; d < 5; d++) begin
                wb_xfer(1'b1, ADCWG_OFS_CTRL, {rnd() & 32'hfffffff8} | 32'(d), rd);
                wb_xfer(1'b0, ADCWG_OFS_CTRL, 32'h0, rd);
                chk("ctrl_div", {29'h0, rd[2:0]}, 32'(d));
                // a mode write stalls at the speed in force before it
                wd = (rnd() & 8'hdf) | 8'(s << 5);
                cpu_u.access(1'b1, ADCWG_TGT_MODE, wd, n);
                e = exp_wait(m_speed, d, 1'b1, ADCWG_TGT_MODE);
                chk("mode_wait", 32'(n), 32'(e));
                m_speed = s;
                chk("speed_out", {31'h0, speed_sel}, 32'(s));
                for (int t = 0; t < 6; t++) begin
                    for (int w = 0; w < 2; w++) begin
                        wd = (rnd() & 8'hdf) | 8'(s << 5);
                        cpu_u.access(w[0], adcwg_target_t'(t), wd, n);
                        e = exp_wait(s, d, w[0], adcwg_target_t'(t));
                        chk("acc_wait", 32'(n), 32'(e));
                    end
                end
                wb_xfer(1'b0, ADCWG_OFS_STAT, 32'h0, rd);
                chk("stat_speed_busy", {30'h0, rd[1:0]}, 32'(s));
                // the last loaded count is that of the result read
                e = exp_wait(s, d, 1'b0, ADCWG_TGT_RESULT);
                chk("stat_last_wait", 32'(rd[ADCWG_STAT_WAIT_LSB +: ADCWG_CNT_W]), 32'(e));
            end
        end
        // deliberate misuse: a waiting access with the oscillator stopped is flagged
        osc_stop <= 1'b1;
        repeat (3) @(posedge clk_i);
        cpu_u.access(1'b0, ADCWG_TGT_RESULT, 8'h00, n);
        e = exp_wait(1, 4, 1'b0, ADCWG_TGT_RESULT);
        chk("osc_acc_wait", 32'(n), 32'(e));
        osc_stop <= 1'b0;
        wb_xfer(1'b0, ADCWG_OFS_STAT, 32'h0, rd);
        chk("stat_osc_set", {31'h0, rd[ADCWG_STAT_OSCV]}, 32'h1);
        wb_xfer(1'b1, ADCWG_OFS_STAT, 32'h1 << ADCWG_STAT_OSCV, rd);
        wb_xfer(1'b0, ADCWG_OFS_STAT, 32'h0, rd);
        chk("stat_osc_clear", {31'h0, rd[ADCWG_STAT_OSCV]}, 32'h0);
        test_done();
    end
endmodule : adcwg_top_test
